// file: cbbh_bank_model.sv
`timescale 1ns/100ps
`default_nettype none
// behavioural memory bank; bank number on line bits 14:13
module cbbh_bank_model #(
  parameter logic [1:0] BANK = 2'h2 // bank switch setting
) (
  input wire logic        ref_clk,         // clock
  input wire logic        slow,            // slow answers
  input wire logic [17:0] lines_n,         // resolved lines
  input wire logic        par_n,           // resolved parity
  input wire logic        read_mode_n,     // read mode
  input wire logic        write_mode_n,    // write mode
  input wire logic        req_n,           // request
  input wire logic        data_ack_n,      // data ack
  input wire logic        cycle_release_n, // release
  output logic     [17:0] drv_n,           // lines drive
  output logic            drv_par_n,       // parity drive
  output logic            drv_oe,          // drive enable
  output logic            busy_n,          // shared busy
  output logic            addr_ack_n,      // address ack
  output logic            rd_valid_n,      // read valid
  output logic            release_ack_n    // release ack
);
  logic [18:0] mem [16]; // small store on low address bits
  logic [3:0]  a;        // latched address
  logic        rd;       // read cycle
  logic        wr;       // write cycle
  initial begin
    {busy_n, addr_ack_n, rd_valid_n, release_ack_n} = 4'hF;
    {drv_oe, drv_par_n, drv_n} = {1'b0, 19'h7FFFF};
    foreach (mem[i]) mem[i] = 19'h00000;
    forever begin
      @(posedge ref_clk);
      if (!req_n && busy_n && ~lines_n[14:13] == BANK) begin
        repeat (slow ? 12 : 6) @(posedge ref_clk);
        a = ~lines_n[3:0];
        rd = !read_mode_n;
        wr = !write_mode_n;
        addr_ack_n <= 1'b0;
        busy_n <= 1'b0;
        while (!req_n) @(posedge ref_clk);
        addr_ack_n <= 1'b1;
        if (rd) begin
          repeat (slow ? 8 : 3) @(posedge ref_clk);
          drv_n <= ~mem[a][17:0];
          drv_par_n <= ~mem[a][18];
          drv_oe <= 1'b1;
          repeat (5) @(posedge ref_clk);
          rd_valid_n <= 1'b0;
          do @(posedge ref_clk); while (data_ack_n);
          drv_oe <= 1'b0;
          rd_valid_n <= 1'b1;
        end
        // a pause cycle simply waits here for new data
        do @(posedge ref_clk); while (cycle_release_n);
        if (wr) mem[a] = {~par_n, ~lines_n};
        release_ack_n <= 1'b0;
        do @(posedge ref_clk); while (!cycle_release_n);
        release_ack_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        busy_n <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: cbbh_host.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RULE1 - bank selected by address bits 03, 04
// RULE2 - bus lines active at ground level
// RULE3 - requester drives 17-bit word address
// RULE4 - 18-bit data both ways, parity optional
// RULE5 - mode lines choose among three cycle types
// RULE6 - busy bank drives shared busy level
// RULE7 - only one memory active at once
// RULE8 - wait busy clear, drive address, mode
// RULE9 - request 50 ns after address, mode
// RULE10 - bank acknowledges about 110 ns later
// RULE11 - acknowledge sets busy, request withdrawn
// RULE12 - bank clears acknowledge when request falls
// RULE13 - read valid only in read cycles
// RULE14 - data acknowledge frees bus in reads
// RULE15 - release reports data taken or placed
// RULE16 - bank acknowledges release, cycle ends
// RULE17 - parity line carries 19th bit
// RULE18 - capture read data on read valid
// RULE19 - drop release on release acknowledge
// RULE20 - write data settles 50 ns before release
// RULE21 - pause cycle waits for modified data
// RULE22 - hold address, mode until acknowledge
module cbbh_host (
  input  wire logic                          ref_clk,       // 50 MHz clock
  input  wire logic                          arst_n,        // async reset
  // user side
  input  wire logic                          cmd_valid,     // start a cycle
  input  wire cbbh_pkg::cbbh_cmd_t           cmd,           // addr/mode/data
  output logic                               cmd_ready,     // idle, can take
  output logic                               rdata_valid,   // read word pulse
  output logic [cbbh_pkg::DATA_W-1:0]        rdata,         // read word
  output logic                               rpar,          // read parity
  output logic                               pause_wait,    // rpw paused
  input  wire logic                          mod_valid,     // modified word in
  input  wire logic [cbbh_pkg::DATA_W-1:0]   mod_data,      // modified word
  input  wire logic                          mod_par,       // modified parity
  output logic                               done,          // cycle end pulse
  // bus side, active low except the two drive enables
  input  wire logic [cbbh_pkg::LINE_W-1:0]   lines_n_i,     // data lines in
  output logic      [cbbh_pkg::LINE_W-1:0]   lines_n_o,     // data lines out
  output logic                               lines_oe,      // drive lines
  input  wire logic                          par_n_i,       // parity in
  output logic                               par_n_o,       // parity out
  output logic                               par_oe,        // drive parity
  output logic                               read_mode_n,   // read mode
  output logic                               write_mode_n,  // write mode
  output logic                               req_n,         // request
  output logic                               data_ack_n,    // data acknowledge
  output logic                               cycle_release_n, // release
  input  wire logic                          busy_n,        // shared busy
  input  wire logic                          addr_ack_n,    // addr acknowledge
  input  wire logic                          rd_valid_n,    // read data valid
  input  wire logic                          release_ack_n  // release ack
);

  ////////////////////////////////////////////////////////////////////
  // synchronise and invert bus inputs
  localparam int IN_W = $bits(cbbh_pkg::cbbh_bus_in_t);
  cbbh_pkg::cbbh_bus_in_t bus_s;  // synchronised, active high
  logic [IN_W-1:0]        raw_in; // ground means one/asserted

  // inverted pins; ground level reads as one
  assign raw_in = ~{lines_n_i, par_n_i, busy_n, addr_ack_n,
                    rd_valid_n, release_ack_n}; // RULE2

  cbbh_sync #(.W(IN_W)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .async_i (raw_in),
    .sync_o  (bus_s)
  );

  ////////////////////////////////////////////////////////////////////
  // state machine
  typedef enum logic [3:0] {
    S_IDLE, S_SETTLE, S_REQ, S_DROP, S_RDWAIT, S_PAUSE,
    S_WSETTLE, S_REL, S_RELDROP
  } cbbh_state_t;

  cbbh_state_t                  st_q, st_d;     // control state
  cbbh_pkg::cbbh_mode_t         mode_q;         // latched cycle type
  logic [cbbh_pkg::ADDR_W-1:0]  addr_q;         // latched address
  logic [cbbh_pkg::DATA_W-1:0]  wdata_q;        // word to write
  logic                         wpar_q;         // parity to write
  logic [cbbh_pkg::CNT_W-1:0]   cnt_q, cnt_d;   // settle counter
  logic                         settled;        // settle time elapsed

  // settle counter reaches the rounded-up 50 ns
  assign settled = (cnt_q >= cbbh_pkg::CNT_W'(cbbh_pkg::SETTLE_CYC - 1));

  // mode helpers
  wire is_read  = mode_q[0]; // read mode line asserted
  wire is_write = mode_q[1]; // write mode line asserted
  wire go       = cmd_valid && (cmd.mode != 2'h0); // at least one mode

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_d  = st_q;
    cnt_d = CNT_RST_F();
    case (st_q)
      S_IDLE: begin
        // busy must be clear before a new cycle
        if (go && !bus_s.busy) st_d = S_SETTLE; // RULE8 RULE6 RULE7
      end
      S_SETTLE: begin
        // address and mode settle before request
        cnt_d = cnt_q + 1'b1;
        if (settled) st_d = S_REQ; // RULE9
      end
      S_REQ: begin
        // hold request until bank acknowledges
        if (bus_s.addr_ack) st_d = S_DROP; // RULE11 RULE10
      end
      S_DROP: begin
        // wait for acknowledge to clear after request falls
        if (!bus_s.addr_ack) begin // RULE12
          if (is_read) st_d = S_RDWAIT;
          else st_d = S_WSETTLE; // RULE20
        end
      end
      S_RDWAIT: begin
        // read data valid only in read cycles
        if (bus_s.rd_valid) begin // RULE13 RULE18
          if (is_write) st_d = S_PAUSE; // RULE21
          else st_d = S_REL;
        end
      end
      S_PAUSE: begin
        // bank pauses until modified word supplied
        if (mod_valid) st_d = S_WSETTLE; // RULE21
      end
      S_WSETTLE: begin
        cnt_d = cnt_q + 1'b1;
        if (settled) st_d = S_REL; // RULE20
      end
      S_REL: begin
        if (bus_s.release_ack) st_d = S_RELDROP; // RULE16
      end
      S_RELDROP: begin
        // release dropped; wait for bank to clear its ack
        if (!bus_s.release_ack) st_d = S_IDLE; // RULE19
      end
      default: st_d = S_IDLE;
    endcase
  end

  // reset value of the settle counter
  function automatic logic [cbbh_pkg::CNT_W-1:0] CNT_RST_F();
    return cbbh_pkg::CNT_RST;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state and command latches
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= S_IDLE;
      cnt_q   <= cbbh_pkg::CNT_RST;
      mode_q  <= cbbh_pkg::CBBH_RD_RESTORE;
      addr_q  <= '0;
      wdata_q <= '0;
      wpar_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      if (st_q == S_IDLE && st_d == S_SETTLE) begin
        // held stable from here through acknowledge
        mode_q  <= cmd.mode;  // RULE22 RULE5
        addr_q  <= cmd.addr;  // RULE3
        wdata_q <= cmd.wdata; // RULE4
        wpar_q  <= cmd.wpar;  // RULE17
      end else if (st_q == S_PAUSE && mod_valid) begin
        wdata_q <= mod_data;
        wpar_q  <= mod_par;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registered bus outputs, decoded from next state
  wire d_addr  = (st_d == S_SETTLE) || (st_d == S_REQ);       // addr phase
  wire d_wdat  = (st_d == S_WSETTLE) ||
                 ((st_d == S_REL) && is_write);               // write data
  wire d_rel   = (st_d == S_REL);                             // release
  wire d_dack  = (st_d == S_PAUSE) || (d_rel && is_read) ||
                 ((st_d == S_WSETTLE) && is_read);            // data ack
  wire d_mode  = d_addr || (st_d == S_DROP);                  // mode lines
  // address for the line drivers, from the command on the first cycle
  wire [cbbh_pkg::ADDR_W-1:0] addr_sel = (st_q == S_IDLE) ? cmd.addr : addr_q;
  // word leaving the pause comes straight from the user, so the
  // modified data gets the whole settle time before release
  wire [cbbh_pkg::DATA_W-1:0] wdat_sel =
         (st_q == S_PAUSE) ? mod_data : wdata_q;              // write word
  wire                        wpar_sel =
         (st_q == S_PAUSE) ? mod_par : wpar_q;                // write parity
  wire [cbbh_pkg::LINE_W-1:0] d_line   = d_addr ?
         cbbh_pkg::LINE_W'(addr_sel) : wdat_sel;              // line value

  // mode for the line drivers, same first-cycle rule
  wire cbbh_pkg::cbbh_mode_t cur_mode = (st_q == S_IDLE) ? cmd.mode : mode_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lines_oe        <= 1'b0;
      lines_n_o       <= {cbbh_pkg::LINE_W{1'b1}};
      par_oe          <= 1'b0;
      par_n_o         <= 1'b1;
      read_mode_n     <= 1'b1;
      write_mode_n    <= 1'b1;
      req_n           <= 1'b1;
      data_ack_n      <= 1'b1;
      cycle_release_n <= 1'b1;
    end else begin
      lines_oe        <= d_addr || d_wdat;
      lines_n_o       <= ~d_line;                              // RULE2
      par_oe          <= d_wdat;                               // RULE17
      par_n_o         <= ~wpar_sel;                            // RULE21
      read_mode_n     <= ~(d_mode && cur_mode[0]);             // RULE5
      write_mode_n    <= ~(d_mode && cur_mode[1]);             // RULE5
      req_n           <= ~(st_d == S_REQ);                     // RULE9 RULE11
      data_ack_n      <= ~d_dack;                              // RULE14
      cycle_release_n <= ~d_rel;                               // RULE15 RULE19
    end
  end

  ////////////////////////////////////////////////////////////////////
  // user-side outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ready   <= 1'b0;
      rdata_valid <= 1'b0;
      rdata       <= '0;
      rpar        <= 1'b0;
      pause_wait  <= 1'b0;
      done        <= 1'b0;
    end else begin
      cmd_ready   <= (st_d == S_IDLE);
      rdata_valid <= (st_q == S_RDWAIT) && bus_s.rd_valid;     // RULE18
      if ((st_q == S_RDWAIT) && bus_s.rd_valid) begin
        rdata <= bus_s.lines;
        rpar  <= bus_s.par;
      end
      pause_wait  <= (st_d == S_PAUSE);
      done        <= (st_q == S_RELDROP) && !bus_s.release_ack;
    end
  end

endmodule

`default_nettype wire

// file: cbbh_host_chk.sv
`timescale 1ns/100ps
`default_nettype none
// pin-level checks on the bus side of the bank controller
module cbbh_host_chk (
  input wire logic        ref_clk,         // clock
  input wire logic        arst_n,          // async reset
  input wire logic [17:0] lines_n_o,       // lines out
  input wire logic        lines_oe,        // lines enable
  input wire logic        par_oe,          // parity enable
  input wire logic        read_mode_n,     // read mode
  input wire logic        write_mode_n,    // write mode
  input wire logic        req_n,           // request
  input wire logic        data_ack_n,      // data ack
  input wire logic        cycle_release_n, // release
  input wire logic        busy_n,          // shared busy
  input wire logic        addr_ack_n,      // address ack
  input wire logic        rd_valid_n,      // read valid
  input wire logic        release_ack_n,   // release ack
  input wire logic        pause_wait       // pause level
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // lines must settle three cycles before a request
  sequence s_settle; req_n [*3]; endsequence
  sequence s_req_off; ##[1:4] req_n; endsequence
  property p_settle; $rose(lines_oe) |-> s_settle; endproperty
  property p_mode; !req_n |-> !(read_mode_n && write_mode_n); endproperty
  property p_busy; $fell(req_n) |-> $past(busy_n, 4); endproperty
  property p_hold; !req_n |-> lines_oe && $stable(lines_n_o); endproperty
  property p_req_drop; $fell(addr_ack_n) |-> s_req_off; endproperty
  property p_rel_drop;
    !release_ack_n && !cycle_release_n |-> ##[1:4] cycle_release_n;
  endproperty
  property p_dack; $fell(data_ack_n) |-> !$past(rd_valid_n, 2); endproperty
  // write data held a full settle before release, parity driven at release
  property p_wr_settle;
    $fell(cycle_release_n) && lines_oe |->
      $past(lines_oe, 3) && par_oe && ($past(lines_n_o, 3) == lines_n_o);
  endproperty
  property p_pause; pause_wait |-> cycle_release_n; endproperty
  a_settle: assert property (p_settle) else $error("early request");
  a_mode: assert property (p_mode) else $error("no mode");
  a_busy: assert property (p_busy) else $error("request on busy");
  a_hold: assert property (p_hold) else $error("address moved");
  a_req_drop: assert property (p_req_drop) else $error("req kept");
  a_rel_drop: assert property (p_rel_drop) else $error("rel kept");
  a_dack: assert property (p_dack) else $error("stray data ack");
  a_wr_settle: assert property (p_wr_settle) else $error("short");
  a_pause: assert property (p_pause) else $error("pause rel");
endmodule
bind cbbh_host cbbh_host_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .lines_n_o(lines_n_o), .lines_oe(lines_oe), .par_oe(par_oe),
  .read_mode_n(read_mode_n), .write_mode_n(write_mode_n), .req_n(req_n),
  .data_ack_n(data_ack_n), .cycle_release_n(cycle_release_n),
  .busy_n(busy_n), .addr_ack_n(addr_ack_n), .rd_valid_n(rd_valid_n),
  .release_ack_n(release_ack_n), .pause_wait(pause_wait));
`default_nettype wire

// file: cbbh_host_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cbbh_host_tb;
  logic                ref_clk = 1'b0;   // 50 MHz
  logic                arst_n = 1'b0;    // reset
  logic                cmd_valid = 1'b0; // command strobe
  cbbh_pkg::cbbh_cmd_t cmd = '0;         // command
  logic                mod_valid = 1'b0; // modified word strobe
  logic [17:0]         mod_data = 18'h00000;
  logic                mod_par = 1'b0;
  logic                slow = 1'b0;      // partner pace
  logic [17:0]         rdata, lines_n_o, bus_n, m_drv_n;
  logic                cmd_ready, rdata_valid, rpar, pause_wait, done;
  logic                lines_oe, par_n_o, par_oe, par_n, rd_n, wr_n, req_n;
  logic                dack_n, rel_n, busy_n, aack_n, rv_n, rack_n;
  logic                parity_bit_line_n, m_oe;
  logic                ext_busy_n = 1'b1; // busy level of another bank
  logic                bus_busy_n;        // resolved shared busy level
  int                  n_fail = 0;
  int                  total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  // released lines rest at the pull-up level
  assign bus_n = lines_oe ? lines_n_o : (m_oe ? m_drv_n : 18'h3FFFF);
  assign par_n = par_oe ? par_n_o : (m_oe ? parity_bit_line_n : 1'b1);
  assign bus_busy_n = busy_n & ext_busy_n;
  cbbh_host dut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rdata_valid(rdata_valid),
    .rdata(rdata), .rpar(rpar), .pause_wait(pause_wait),
    .mod_valid(mod_valid), .mod_data(mod_data), .mod_par(mod_par),
    .done(done), .lines_n_i(bus_n), .lines_n_o(lines_n_o),
    .lines_oe(lines_oe), .par_n_i(par_n), .par_n_o(par_n_o),
    .par_oe(par_oe), .read_mode_n(rd_n), .write_mode_n(wr_n),
    .req_n(req_n), .data_ack_n(dack_n), .cycle_release_n(rel_n),
    .busy_n(bus_busy_n), .addr_ack_n(aack_n), .rd_valid_n(rv_n),
    .release_ack_n(rack_n));
  cbbh_bank_model #(.BANK(2'h2)) u_bank (.ref_clk(ref_clk), .slow(slow),
    .lines_n(bus_n), .par_n(par_n), .read_mode_n(rd_n),
    .write_mode_n(wr_n), .req_n(req_n), .data_ack_n(dack_n),
    .cycle_release_n(rel_n), .drv_n(m_drv_n), .drv_par_n(parity_bit_line_n),
    .drv_oe(m_oe), .busy_n(busy_n), .addr_ack_n(aack_n),
    .rd_valid_n(rv_n), .release_ack_n(rack_n));
  task automatic chk(input string nm, input logic [18:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one bus cycle; command held until taken, busy refusals included
  task automatic run(input logic [1:0] m, input logic [16:0] ad,
                     input logic [18:0] wd, md, output logic [18:0] rd);
    int   n;
    logic got_a;
    logic dack;
    {n, got_a, dack, rd} = {32'h0, 2'h0, 19'h7FFFF};
    cmd_valid <= 1'b1;
    cmd <= '{ad, cbbh_pkg::cbbh_mode_t'(m), wd[17:0], wd[18]};
    {mod_par, mod_data} <= md;
    do begin
      @(posedge ref_clk);
      n++;
      if (!cmd_ready) cmd_valid <= 1'b0;
      if (!req_n && !got_a) begin
        got_a = 1'b1;
        chk("addr", {1'b0, lines_n_o}, {1'b0, ~{1'b0, ad}});
      end
      if (!dack_n) dack = 1'b1;
      if (rdata_valid) rd = {rpar, rdata};
      mod_valid <= pause_wait;
    end while (!done && n < 900);
    chk("done", {18'h0, done}, 19'h1);
    chk("data_ack", {18'h0, dack}, {18'h0, m[0]});
    @(posedge ref_clk);
    {cmd_valid, mod_valid} <= 2'h0;
    @(posedge ref_clk);
  endtask
  // no mode line: nothing may reach the bus
  task automatic t_refuse;
    logic seen;
    seen = 1'b0;
    cmd_valid <= 1'b1;
    cmd <= '{17'h04001, cbbh_pkg::cbbh_mode_t'(2'h0), 18'h00000, 1'b0};
    repeat (12) begin
      @(posedge ref_clk);
      if (!req_n || lines_oe) seen = 1'b1;
    end
    cmd_valid <= 1'b0;
    chk("refused", {18'h0, seen}, 19'h0);
    chk("ready", {18'h0, cmd_ready}, 19'h1);
    @(posedge ref_clk);
  endtask
  // another bank busy: no request until its level is released
  task automatic t_busy;
    logic [18:0] r;
    logic        seen;
    seen = 1'b0;
    ext_busy_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    fork
      run(2'h1, 17'h04005, 19'h00000, 19'h00000, r);
      begin
        repeat (20) begin
          @(posedge ref_clk);
          if (!req_n || lines_oe) seen = 1'b1;
        end
        ext_busy_n <= 1'b1;
      end
    join
    chk("busy_hold", {18'h0, seen}, 19'h0);
    chk("busy_rd", r, 19'h5A5C3);
  endtask
  // write, then restore reads twice back to back
  task automatic t_write_read;
    logic [18:0] r;
    run(2'h2, 17'h04005, 19'h5A5C3, 19'h00000, r);
    run(2'h1, 17'h04005, 19'h00000, 19'h00000, r);
    chk("rd_first", r, 19'h5A5C3);
    run(2'h1, 17'h04005, 19'h00000, 19'h00000, r);
    chk("rd_restore", r, 19'h5A5C3);
  endtask
  // read, pause, write back a modified word
  task automatic t_rpw;
    logic [18:0] r;
    run(2'h2, 17'h0400A, 19'h00FF0, 19'h00000, r);
    run(2'h3, 17'h0400A, 19'h00000, 19'h4F00F, r);
    chk("rpw_old", r, 19'h00FF0);
    run(2'h1, 17'h0400A, 19'h00000, 19'h00000, r);
    chk("rpw_new", r, 19'h4F00F);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_refuse;
    t_write_read;
    t_busy;
    t_rpw;
    slow <= 1'b1;
    t_write_read;
    close_out;
  end
  // whole run needs about 500 cycles
  initial begin
    #(200000);
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire

// file: cbbh_pkg.sv
package cbbh_pkg;

  // bus word and address widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 18;
  localparam int LINE_W = 18;

  // bus settling time before request and before release, in ns
  localparam int SETTLE_NS  = 50;
  localparam int CLK_NS     = 20;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // counter width for settle delays
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

  // cycle types, as mode line pairs
  typedef enum logic [1:0] {
    CBBH_RD_RESTORE = 2'h1,
    CBBH_CLR_WRITE  = 2'h2,
    CBBH_RD_PAUSE_WR = 2'h3
  } cbbh_mode_t;

  // user-side command
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    cbbh_mode_t        mode;
    logic [DATA_W-1:0] wdata;
    logic              wpar;
  } cbbh_cmd_t;

  // bus inputs as seen by the controller, active high after inversion
  typedef struct packed {
    logic [LINE_W-1:0] lines;
    logic              par;
    logic              busy;
    logic              addr_ack;
    logic              rd_valid;
    logic              release_ack;
  } cbbh_bus_in_t;

endpackage

// file: cbbh_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for bus inputs arriving without a clock
module cbbh_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk, // system clock
  input  wire logic         arst_n,  // async reset, active low
  input  wire logic [W-1:0] async_i, // raw pin levels
  output logic      [W-1:0] sync_o   // synchronised levels
);

  logic [W-1:0] meta_q; // first stage, read only by second stage

  ////////////////////////////////////////////////////////////////////
  // two flops in series; nothing taps the first
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

`default_nettype wire
